/* File: dtfs_defs.svh */
// Offsets, reset values and timing counts of the terminal-function block.
// Assumes a 200 MHz clock and a byte-addressed Avalon-MM register window.
`ifndef DTFS_DEFS_SVH
`define DTFS_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define DTFS_OFF_TFS 8'h00
`define DTFS_OFF_SMS 8'h04
`define DTFS_OFF_AUX 8'h08
`define DTFS_OFF_AIS 8'h0C
`define DTFS_OFF_MODE 8'h10
`define DTFS_OFF_LOCK 8'h14
`define DTFS_OFF_FGAIN 8'h18
`define DTFS_OFF_CGAIN 8'h1C
`define DTFS_OFF_STAT 8'h20

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DTFS_RST_TFS 4'h0
`define DTFS_RST_SMS 4'h0
`define DTFS_RST_AUX 4'h0
`define DTFS_RST_AIS 2'h0
`define DTFS_RST_LOCK 16'h0001
`define DTFS_RST_GAIN 16'h1000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DTFS_TFS_KSTOP 0
`define DTFS_TFS_NOREV 1
`define DTFS_TFS_ONCE 2
`define DTFS_TFS_AOSEL 3
`define DTFS_SMS_KPSRC 1
`define DTFS_AUX_AOSEL 1
`define DTFS_TRM_FWD 0
`define DTFS_TRM_REV 1
`define DTFS_TRM_DCB 3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DTFS_CLK_NS 5
`define DTFS_MS_NS 1000000
`define DTFS_MS_CYC (`DTFS_MS_NS / `DTFS_CLK_NS)
`define DTFS_BLINK_MS 8'hFA

`endif

/* File: dtfs_pkg.sv */
// Types shared by the terminal-function block files.
// Assumes dtfs_defs.svh is on the include path.
package dtfs_pkg;
  // Stop method, order matches the two-bit setting field
  typedef enum logic [1:0] {
    DTFS_RAMP,
    DTFS_COAST,
    DTFS_DCBRAKE,
    DTFS_COAST_TIMER
  } dtfs_stop_e;

  // Control mode; the last one is encoder feedback
  typedef enum logic [1:0] {
    DTFS_GP_VF,
    DTFS_SENSORLESS,
    DTFS_PROCESS,
    DTFS_ENCODER
  } dtfs_mode_e;

  // Whole state of the top module
  typedef struct packed {
    logic wreq;
    logic [31:0] rdata;
    logic [3:0] tfs;
    logic [3:0] sms;
    logic [3:0] aux;
    logic [1:0] ais;
    dtfs_mode_e mode;
    logic [15:0] lock_ms;
    logic [15:0] fgain;
    logic [15:0] cgain;
    logic [17:0] pre;
    logic [15:0] lock_cnt;
    logic running;
    logic rev;
    logic kp_run;
    logic stop_latch;
    logic [3:0] ref_prev;
    logic prog;
    logic blink;
    logic [7:0] blink_ms;
    dtfs_stop_e stop_m;
    logic [11:0] aout;
  } dtfs_state_s;
endpackage : dtfs_pkg

/* File: dtfs_scan_if.sv */
// Carrier between the top and the sequence-input scanner.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface dtfs_scan_if;
  logic [7:0] raw;
  logic once;
  logic [7:0] filt;
  modport scanner (input raw, input once, output filt);
  modport user (output raw, output once, input filt);
endinterface : dtfs_scan_if

/* File: dtfs_scan.sv */
// Sequence-input scanner: single or double sampling of eight terminals.
// Assumes terminal levels already synchronous to mclk_in.
`timescale 1ns/1ps
module dtfs_scan (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Terminal carrier
  dtfs_scan_if.scanner sc
);
  import dtfs_pkg::*;

  typedef struct packed {
    logic [7:0] last;
    logic [7:0] filt;
  } dtfs_scan_s;

  dtfs_scan_s s;
  dtfs_scan_s next_s;

  // ----------------------------------------------------------------------
  // Scan logic
  // ----------------------------------------------------------------------
  // Twice: a level must be seen on two scans in a row; rejects one-scan glitches
  always_comb begin
    next_s = s;
    next_s.last = sc.raw;
    if (sc.once) begin
      next_s.filt = sc.raw;
    end else if (sc.raw == s.last) begin
      next_s.filt = sc.raw;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sc.filt = s.filt;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  scan_twice_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ($changed(s.filt) && !$past(sc.once)) |-> ($past(sc.raw) == $past(sc.raw, 2)))
    else $error("double scan accepted a single sample");
endmodule : dtfs_scan

/* File: dtfs_top.sv */
// Terminal-function control of a motor drive: keypad stop, reverse lock,
// input scanning, analog output source and coast lockout.
// Assumes keypad keys are one-cycle pulses and all inputs synchronous.
`timescale 1ns/1ps
`include "dtfs_defs.svh"

// Functional notes
// - With timed coast selected, run commands are ignored for the lockout time after a stop.
// - Terminal setting digit one at 0 makes the keypad stop key act during terminal running.
// - Such a keypad stop uses the configured stop method and blinks the stop indicator.
// - The keypad stop is held until both terminal run inputs open or the step reference changes.
// - Terminal setting digit one at 1 makes the keypad stop key ignored during terminal running.
// - Terminal setting digit two at 1 rejects reverse run from terminals and keypad alike.
// - Digit three picks double scanning (0) or single scanning (1) of the eight inputs.
// - Digit four with the auxiliary digit two picks frequency, current, voltage or power.
// - Frequency and current outputs are scaled so full scale is max frequency and rated current.
// - In encoder mode digit four is ignored and the item selector chooses the analog item.
// - The mode key and keypad run act only while stopped with run and brake inputs open.
module dtfs_top #(
  parameter int MS_CYCLES = `DTFS_MS_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Avalon-MM slave
  input wire logic [7:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  // Control terminals and keypad
  input wire logic [7:0] terminals_in,
  input wire logic key_run_in,
  input wire logic key_stop_in,
  input wire logic key_rev_in,
  input wire logic key_mode_in,
  // Analog sources
  input wire logic [15:0] out_freq_in,
  input wire logic [15:0] out_curr_in,
  input wire logic [15:0] volt_ref_in,
  input wire logic [15:0] out_pwr_in,
  // Motor stage and operator
  output logic motor_run_out,
  output logic motor_rev_out,
  output dtfs_pkg::dtfs_stop_e stop_method_out,
  output logic stop_led_blink_out,
  output logic program_mode_out,
  output logic [11:0] analog_out
);
  import dtfs_pkg::*;

  localparam logic [17:0] PRE_MAX = 18'(MS_CYCLES - 1);

  dtfs_state_s s;
  dtfs_state_s next_s;
  dtfs_scan_if sc ();

  logic ms_tick;
  logic req;
  logic stopped;
  logic kp_src;
  logic lock;
  logic ref_chg;
  logic fwd_d;
  logic rev_d;
  logic run_d;
  logic [1:0] ao_code;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Gain is full-scale reciprocal in 4.12 form; saturates rather than wraps
  function automatic logic [11:0] scale(input logic [15:0] v, input logic [15:0] g);
    logic [31:0] p;
    p = v * g;
    if (p[31:28] != 4'h0) begin
      return 12'hFFF;
    end
    return p[27:16];
  endfunction : scale

  // ----------------------------------------------------------------------
  // Input scanner
  // ----------------------------------------------------------------------
  assign sc.raw = terminals_in;
  assign sc.once = s.tfs[`DTFS_TFS_ONCE];

  dtfs_scan u_scan (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .sc(sc)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    ms_tick = (s.pre == PRE_MAX);
    next_s.pre = ms_tick ? 18'h0 : s.pre + 18'h1;
    stopped = !s.running && !sc.filt[`DTFS_TRM_FWD] && !sc.filt[`DTFS_TRM_REV] && !sc.filt[`DTFS_TRM_DCB];

    // Bus: one wait cycle, then the access completes with waitrequest low
    req = (read_in || write_in) && s.wreq;
    next_s.wreq = !req;
    // Write lands at the completing edge, the one where the master sees waitrequest low
    if (write_in && !s.wreq) begin
      unique case (address_in)
        `DTFS_OFF_TFS: begin
          if (stopped) begin
            next_s.tfs = writedata_in[3:0];
          end
        end
        `DTFS_OFF_SMS: next_s.sms = writedata_in[3:0];
        `DTFS_OFF_AUX: next_s.aux = writedata_in[3:0];
        `DTFS_OFF_AIS: next_s.ais = writedata_in[1:0];
        `DTFS_OFF_MODE: next_s.mode = dtfs_mode_e'(writedata_in[1:0]);
        `DTFS_OFF_LOCK: next_s.lock_ms = writedata_in[15:0];
        `DTFS_OFF_FGAIN: next_s.fgain = writedata_in[15:0];
        `DTFS_OFF_CGAIN: next_s.cgain = writedata_in[15:0];
        default: next_s.rdata = s.rdata;
      endcase
    end
    // Read data captured in the wait cycle, so it stands with waitrequest low
    next_s.rdata = 32'h0;
    if (req && read_in) begin
      unique case (address_in)
        `DTFS_OFF_TFS: next_s.rdata = {28'h0, s.tfs};
        `DTFS_OFF_SMS: next_s.rdata = {28'h0, s.sms};
        `DTFS_OFF_AUX: next_s.rdata = {28'h0, s.aux};
        `DTFS_OFF_AIS: next_s.rdata = {30'h0, s.ais};
        `DTFS_OFF_MODE: next_s.rdata = {30'h0, s.mode};
        `DTFS_OFF_LOCK: next_s.rdata = {16'h0, s.lock_ms};
        `DTFS_OFF_FGAIN: next_s.rdata = {16'h0, s.fgain};
        `DTFS_OFF_CGAIN: next_s.rdata = {16'h0, s.cgain};
        `DTFS_OFF_STAT: next_s.rdata = {26'h0, lock, s.blink, s.stop_latch, s.prog, s.rev, s.running};
        default: next_s.rdata = 32'h0;
      endcase
    end

    // Program/drive key only toggles at standstill
    if (key_mode_in && stopped) begin
      next_s.prog = !s.prog;
    end

    // Coast lockout counts down in milliseconds
    lock = (s.lock_cnt != 16'h0);
    if (lock && ms_tick) begin
      next_s.lock_cnt = s.lock_cnt - 16'h1;
    end

    // Keypad run source: run key only from standstill in drive mode
    kp_src = s.sms[`DTFS_SMS_KPSRC];
    if (!kp_src || key_stop_in) begin
      next_s.kp_run = 1'b0;
    end else if (key_run_in && !s.prog && stopped) begin
      next_s.kp_run = 1'b1;
    end

    // Held keypad stop during terminal running; the set wins over the clear
    ref_chg = (sc.filt[7:4] != s.ref_prev);
    next_s.ref_prev = sc.filt[7:4];
    if (!kp_src && s.running && !s.tfs[`DTFS_TFS_KSTOP] && key_stop_in) begin
      next_s.stop_latch = 1'b1;
    end else if ((!sc.filt[`DTFS_TRM_FWD] && !sc.filt[`DTFS_TRM_REV]) || ref_chg) begin
      next_s.stop_latch = 1'b0;
    end
    // With digit one at 1 the key simply does not reach the latch

    // Run demand; both terminal directions at once means stop
    fwd_d = kp_src ? (s.kp_run && !key_rev_in)
                   : (sc.filt[`DTFS_TRM_FWD] && !sc.filt[`DTFS_TRM_REV]);
    rev_d = kp_src ? (s.kp_run && key_rev_in)
                   : (sc.filt[`DTFS_TRM_REV] && !sc.filt[`DTFS_TRM_FWD]);
    if (s.tfs[`DTFS_TFS_NOREV]) begin
      rev_d = 1'b0;
    end
    run_d = (fwd_d || rev_d) && !next_s.stop_latch && !lock && !s.prog;
    next_s.running = run_d;
    next_s.rev = run_d && rev_d;

    // Stop event: hand the configured method to the output stage
    if (s.running && !run_d) begin
      next_s.stop_m = dtfs_stop_e'(s.sms[3:2]);
      if (dtfs_stop_e'(s.sms[3:2]) == DTFS_COAST_TIMER) begin
        next_s.lock_cnt = s.lock_ms;
      end
    end

    // Stop indicator blinks while the keypad stop is held
    if (s.stop_latch) begin
      if (ms_tick) begin
        if (s.blink_ms == `DTFS_BLINK_MS) begin
          next_s.blink_ms = 8'h0;
          next_s.blink = !s.blink;
        end else begin
          next_s.blink_ms = s.blink_ms + 8'h1;
        end
      end
    end else begin
      next_s.blink_ms = 8'h0;
      next_s.blink = 1'b0;
    end

    // Analog item; encoder mode uses its own selector
    if (s.mode == DTFS_ENCODER) begin
      ao_code = s.ais;
    end else begin
      ao_code = {s.aux[`DTFS_AUX_AOSEL], s.tfs[`DTFS_TFS_AOSEL]};
    end
    unique case (ao_code)
      2'h0: next_s.aout = scale(out_freq_in, s.fgain);
      2'h1: next_s.aout = scale(out_curr_in, s.cgain);
      2'h2: next_s.aout = volt_ref_in[15:4];
      2'h3: next_s.aout = out_pwr_in[15:4];
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s <= '0;
      s.wreq <= 1'b1;
      s.tfs <= `DTFS_RST_TFS;
      s.sms <= `DTFS_RST_SMS;
      s.aux <= `DTFS_RST_AUX;
      s.ais <= `DTFS_RST_AIS;
      s.mode <= DTFS_GP_VF;
      s.lock_ms <= `DTFS_RST_LOCK;
      s.fgain <= `DTFS_RST_GAIN;
      s.cgain <= `DTFS_RST_GAIN;
      s.stop_m <= DTFS_RAMP;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign readdata_out = s.rdata;
  assign waitrequest_out = s.wreq;
  assign motor_run_out = s.running;
  assign motor_rev_out = s.rev;
  assign stop_method_out = s.stop_m;
  assign stop_led_blink_out = s.blink;
  assign program_mode_out = s.prog;
  assign analog_out = s.aout;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  lockout_start_a: assert property ($rose(s.running) |-> $past(s.lock_cnt) == 16'h0)
    else $error("run started during coast lockout");
  lockout_load_a: assert property (
    ($fell(s.running) && $past(s.sms[3:2]) == 2'h3) |-> s.lock_cnt == $past(s.lock_ms))
    else $error("coast lockout not loaded");
  kp_stop_a: assert property (
    (s.running && !kp_src && !s.tfs[0] && key_stop_in) |=> (s.stop_latch && !s.running))
    else $error("keypad stop not honoured");
  stop_method_a: assert property ($fell(s.running) |-> s.stop_m == dtfs_stop_e'($past(s.sms[3:2])))
    else $error("wrong stop method");
  latch_clear_a: assert property (
    (s.stop_latch && !key_stop_in && !sc.filt[0] && !sc.filt[1]) |=> !s.stop_latch)
    else $error("stop latch not released");
  kp_ignore_a: assert property (
    (s.running && !kp_src && s.tfs[0] && !s.stop_latch) |=> !s.stop_latch)
    else $error("keypad stop taken with digit one set");
  rev_block_a: assert property ((s.running && s.tfs[1]) |-> !s.rev)
    else $error("reverse run while prohibited");
  ao_volt_a: assert property (
    (s.mode != DTFS_ENCODER && s.aux[1] && !s.tfs[3]) |=> s.aout == $past(volt_ref_in[15:4]))
    else $error("analog output not voltage reference");
  ao_enc_a: assert property (
    (s.mode == DTFS_ENCODER && s.ais == 2'h3) |=> s.aout == $past(out_pwr_in[15:4]))
    else $error("encoder mode analog item wrong");
  tfs_change_a: assert property ($changed(s.tfs) |-> $past(stopped))
    else $error("terminal setting changed while running");
  mode_key_a: assert property ($changed(s.prog) |-> $past(key_mode_in && stopped))
    else $error("mode key acted while running");
  bus_ack_a: assert property ((s.wreq && (read_in || write_in)) |=> !s.wreq)
    else $error("bus access not answered in one cycle");

  kp_stop_c: cover property (s.running ##1 s.stop_latch ##[1:20] !s.stop_latch);
  lockout_c: cover property ($fell(s.running) && s.lock_cnt != 16'h0);
  ao_pwr_c: cover property (s.mode != DTFS_ENCODER && s.aux[1] && s.tfs[3]);
  rev_run_c: cover property (s.running && s.rev);
endmodule : dtfs_top

/* File: dtfs_kpad.sv */
// Keypad operator and sequence terminal model facing the block.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/1ps
module dtfs_kpad (
  // Clock
  input wire logic mclk_in,
  // Terminals and keypad
  output logic [7:0] terminals_out,
  output logic key_run_out,
  output logic key_stop_out,
  output logic key_mode_out,
  output logic key_rev_out
);
  // All lines defined from time zero
  initial begin
    terminals_out = 8'h00;
    key_run_out = 1'b0;
    key_stop_out = 1'b0;
    key_mode_out = 1'b0;
    key_rev_out = 1'b0;
  end

  // Terminal and direction levels move only after an edge
  task set_term(input logic [7:0] v, input logic r);
    terminals_out <= v;
    key_rev_out <= r;
  endtask : set_term

  // Key pulse of one cycle: 0 run, 1 stop, 2 mode
  task press(input int k);
    key_run_out <= (k == 0);
    key_stop_out <= (k == 1);
    key_mode_out <= (k == 2);
    @(posedge mclk_in);
    key_run_out <= 1'b0;
    key_stop_out <= 1'b0;
    key_mode_out <= 1'b0;
  endtask : press
endmodule : dtfs_kpad

/* File: dtfs_tb_top.sv */
// Self-checking bench of the terminal-function block.
// Assumes a 1 ms tick shortened to 20 cycles for run time.
`timescale 1ns/1ps
`include "dtfs_defs.svh"
module dtfs_tb_top;
  import dtfs_pkg::*;
  localparam int LIMIT = 40000;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] address_in = 8'h00;
  logic read_in = 1'b0;
  logic write_in = 1'b0;
  logic [31:0] writedata_in = 32'h0;
  logic [15:0] freq = 16'h1230;
  logic [15:0] curr = 16'h4560;
  logic [15:0] volt = 16'h789A;
  logic [15:0] pwr = 16'hABCD;
  logic [31:0] readdata_out, q;
  logic waitrequest_out, k_run, k_stop, k_mode, k_rev;
  logic m_run, m_rev, blink, prog;
  logic [7:0] term;
  logic [11:0] aout;
  dtfs_stop_e smeth;
  logic [11:0] ex [4] = '{12'h123, 12'h456, 12'h789, 12'hABC};
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;

  dtfs_kpad dtfs_kpad_inst (.mclk_in(mclk_in), .terminals_out(term), .key_run_out(k_run),
    .key_stop_out(k_stop), .key_mode_out(k_mode), .key_rev_out(k_rev));
  dtfs_top #(.MS_CYCLES(20)) dtfs_top_inst (.mclk_in(mclk_in), .rst_in(rst_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
    .terminals_in(term), .key_run_in(k_run), .key_stop_in(k_stop), .key_rev_in(k_rev),
    .key_mode_in(k_mode), .out_freq_in(freq), .out_curr_in(curr), .volt_ref_in(volt),
    .out_pwr_in(pwr), .motor_run_out(m_run), .motor_rev_out(m_rev),
    .stop_method_out(smeth), .stop_led_blink_out(blink), .program_mode_out(prog),
    .analog_out(aout));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  initial forever #2.5 mclk_in = ~mclk_in;

  // A hang anywhere ends the run as a failure
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      mismatches++;
      results();
    end
  end

  task results;
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Avalon cycle; ends one edge after release so calls chain safely
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    address_in <= a;
    writedata_in <= d;
    write_in <= w;
    read_in <= !w;
    do begin
      @(posedge mclk_in);
      t++;
    end while (waitrequest_out !== 1'b0 && t < 40);
    q = readdata_out;
    if (t >= 40) mismatches++;
    read_in <= 1'b0;
    write_in <= 1'b0;
    @(posedge mclk_in);
  endtask : bus

  // Edges until the run output reaches v, sampled before each edge
  task wrun(input logic v);
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (m_run !== v && n < 6000);
  endtask : wrun

  task tk(input int c);
    repeat (c) @(posedge mclk_in);
  endtask : tk

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_scan;
    bus(0, `DTFS_OFF_TFS, 0);
    chk(q, 0);
    bus(0, 8'h40, 0);
    chk(q, 0);
    dtfs_kpad_inst.set_term(8'h01, 0);
    wrun(1);
    chk(n, 4);
    dtfs_kpad_inst.set_term(8'h00, 0);
    wrun(0);
    bus(1, `DTFS_OFF_TFS, 4);
    dtfs_kpad_inst.set_term(8'h01, 0);
    wrun(1);
    chk(n, 3);
    // Setting must not move while running
    bus(1, `DTFS_OFF_TFS, 0);
    bus(0, `DTFS_OFF_TFS, 0);
    chk(q, 4);
    dtfs_kpad_inst.set_term(8'h00, 0);
    wrun(0);
    bus(1, `DTFS_OFF_TFS, 0);
  endtask : t_scan

  task t_kstop;
    bus(1, `DTFS_OFF_SMS, 4);
    dtfs_kpad_inst.set_term(8'h01, 0);
    wrun(1);
    dtfs_kpad_inst.press(1);
    wrun(0);
    chk(n < 6, 1);
    chk(smeth, DTFS_COAST);
    // Indicator blinks while the stop is held, FWD still closed
    n = 0;
    while (blink !== 1'b1 && n < 5400) begin
      @(posedge mclk_in);
      n++;
    end
    chk(blink, 1);
    chk(m_run, 0);
    dtfs_kpad_inst.set_term(8'h11, 0);
    wrun(1);
    chk(n < 10, 1);
    dtfs_kpad_inst.press(1);
    wrun(0);
    dtfs_kpad_inst.set_term(8'h00, 0);
    tk(6);
    dtfs_kpad_inst.set_term(8'h01, 0);
    wrun(1);
    chk(n, 4);
    dtfs_kpad_inst.set_term(8'h00, 0);
    wrun(0);
    // Stop key ignored in terminal running
    bus(1, `DTFS_OFF_TFS, 1);
    dtfs_kpad_inst.set_term(8'h01, 0);
    wrun(1);
    dtfs_kpad_inst.press(1);
    tk(8);
    chk(m_run, 1);
    dtfs_kpad_inst.set_term(8'h00, 0);
    wrun(0);
  endtask : t_kstop

  task t_rev;
    bus(1, `DTFS_OFF_TFS, 2);
    dtfs_kpad_inst.set_term(8'h02, 0);
    tk(10);
    chk(m_run, 0);
    dtfs_kpad_inst.set_term(8'h00, 1);
    bus(1, `DTFS_OFF_SMS, 2);
    dtfs_kpad_inst.press(0);
    tk(10);
    chk(m_run, 0);
    dtfs_kpad_inst.set_term(8'h00, 0);
    bus(1, `DTFS_OFF_SMS, 0);
    bus(1, `DTFS_OFF_TFS, 0);
    dtfs_kpad_inst.set_term(8'h02, 0);
    wrun(1);
    chk(m_rev, 1);
    // Mode key refused while running
    dtfs_kpad_inst.press(2);
    tk(2);
    chk(prog, 0);
    dtfs_kpad_inst.set_term(8'h00, 0);
    wrun(0);
    tk(4);
    dtfs_kpad_inst.press(2);
    tk(2);
    chk(prog, 1);
    dtfs_kpad_inst.set_term(8'h01, 0);
    tk(10);
    chk(m_run, 0);
    dtfs_kpad_inst.set_term(8'h00, 0);
    tk(6);
    dtfs_kpad_inst.press(2);
    tk(2);
    chk(prog, 0);
  endtask : t_rev

  task t_coast;
    bus(1, `DTFS_OFF_LOCK, 2);
    bus(1, `DTFS_OFF_SMS, 8'h0C);
    dtfs_kpad_inst.set_term(8'h01, 0);
    wrun(1);
    dtfs_kpad_inst.set_term(8'h00, 0);
    wrun(0);
    chk(smeth, DTFS_COAST_TIMER);
    dtfs_kpad_inst.set_term(8'h01, 0);
    wrun(1);
    chk(n >= 18 && n <= 50, 1);
    dtfs_kpad_inst.set_term(8'h00, 0);
    wrun(0);
    bus(1, `DTFS_OFF_SMS, 0);
  endtask : t_coast

  task t_aout;
    for (int i = 0; i < 4; i++) begin
      bus(1, `DTFS_OFF_TFS, i[0] << 3);
      bus(1, `DTFS_OFF_AUX, i[1] << 1);
      tk(3);
      chk(aout, ex[i]);
    end
    // Gain past full scale clips at the top code
    bus(1, `DTFS_OFF_AUX, 0);
    bus(1, `DTFS_OFF_TFS, 0);
    bus(1, `DTFS_OFF_FGAIN, 32'h2000);
    freq <= 16'h9000;
    tk(3);
    chk(aout, 12'hFFF);
    bus(1, `DTFS_OFF_TFS, 8);
    bus(1, `DTFS_OFF_CGAIN, 32'h0800);
    tk(3);
    chk(aout, 12'h22B);
    bus(1, `DTFS_OFF_MODE, 3);
    bus(1, `DTFS_OFF_AIS, 2);
    tk(3);
    chk(aout, 12'h789);
    // Encoder selector follows a moving source
    volt <= 16'h1110;
    tk(3);
    chk(aout, 12'h111);
    bus(1, `DTFS_OFF_AIS, 3);
    pwr <= 16'h2220;
    tk(3);
    chk(aout, 12'h222);
    bus(1, `DTFS_OFF_AIS, 1);
    curr <= 16'h3330;
    tk(3);
    chk(aout, 12'h199);
  endtask : t_aout

  // Main sequence
  initial begin
    tk(2);
    rst_in <= 1'b0;
    t_scan();
    t_kstop();
    t_rev();
    t_coast();
    t_aout();
    results();
  end
endmodule : dtfs_tb_top
